// >>> code_source.sv
module code_source (
  // Clock
  input wire logic sys_clk_in,
  // Code word handshake
  input wire logic code_ready_in,
  output logic code_valid_out,
  output video_recon_pkg::sym_code_t code_out
);
  timeunit 1ns;
  timeprecision 1ns;
  video_recon_pkg::sym_code_t words[$];
  logic ready_seen = 1'b0;
  initial begin
    code_valid_out = 1'b0;
    code_out = '0;
  end
  task automatic send(input video_recon_pkg::code_kind_t kind, input logic [5:0] word);
    words.push_back('{kind: kind, word: word});
  endtask
  function automatic int pending();
    return words.size();
  endfunction
  // Offer held until taken; idle lines toggle so a stale word never looks valid
  always @(negedge sys_clk_in) begin
    if (code_valid_out && ready_seen) begin
      void'(words.pop_front());
    end
    if (words.size() > 0) begin
      code_valid_out = 1'b1;
      code_out = words[0];
    end else begin
      code_valid_out = 1'b0;
      code_out = ~code_out;
    end
    ready_seen = code_ready_in;
  end
endmodule

// >>> video_delta_value_reconstructor.sv
//////////////////////////////////////////////////////////////////////////////
module code_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_t;

  ptr_t r;
  ptr_t next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (r.wr == r.rd);
  assign full = (r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;
  assign out_data_out = mem[r.rd[AW-1:0]];

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.wr = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Storage carries no reset, only pointers do
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[r.wr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Justified word staged, then held, feeding selector
// - Code hold steers selector; absolute passes held
// - Video value MSB-justified by quant level
// - Delta code selects arithmetic result instead
// - Code converted to signed delta register
// - Signed delta added to previous video value
// - Overflow or underflow suppresses value update
// - Sync code ends line, starts special sequence
// - First discard next buffer word undecoded
// - Then load six-bit absolute video value
// - Then store two-bit level for next line
// - Decode three words to prime pipeline
// - Halt until restart from sync generator
// - Source switch picks reconstructor or decoder
// - Quant level holds 4, 5, 6 bits
// - Code staged then moved to code hold
module video_delta_value_reconstructor (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Code words from the code detector
  input wire logic code_valid_in,
  output logic code_ready_out,
  input wire video_recon_pkg::sym_code_t code_in,
  // Sync generator
  input wire logic restart_in,
  // Sample from the zero-order reconstructor
  input wire logic [video_recon_pkg::SAMPLE_W-1:0] recon_sample_in,
  // Front panel source switch, high selects the decoder
  input wire logic source_select_switch_in,
  // Sample to the D/A converter
  output logic [video_recon_pkg::SAMPLE_W-1:0] dac_sample_out,
  // Status
  output logic halted_out
);
  typedef struct packed {
    video_recon_pkg::dec_state_t st;
    logic [1:0] prime_cnt;
    logic [1:0] quant_level;
    logic [1:0] quant_pending;
    logic [5:0] justified;
    logic [5:0] held;
    video_recon_pkg::sym_code_t code_stage;
    video_recon_pkg::sym_code_t code_hold;
    logic delta_neg;
    logic [5:0] delta_mag;
    logic [5:0] video;
    logic [5:0] dac;
    logic [2:0] sel_sync;
    logic sel;
  } state_t;

  state_t r;
  state_t next_r;

  logic fifo_valid;
  logic pop;
  video_recon_pkg::sym_code_t sym;
  logic [6:0] sum;
  logic out_of_range;
  logic advance;

  function automatic logic [5:0] lsb_just(input logic [5:0] w, input logic [1:0] ql);
    unique case (ql)
      video_recon_pkg::QL_FIVE: lsb_just = w >> 1;
      video_recon_pkg::QL_FOUR: lsb_just = w >> 2;
      default: lsb_just = w;
    endcase
  endfunction

  function automatic logic [5:0] msb_just(input logic [5:0] w, input logic [1:0] ql);
    unique case (ql)
      video_recon_pkg::QL_FIVE: msb_just = w << 1;
      video_recon_pkg::QL_FOUR: msb_just = w << 2;
      default: msb_just = w;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Buffer between code detector and value logic
  code_fifo #(
    .WIDTH(video_recon_pkg::SYM_W),
    .DEPTH(video_recon_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .in_valid_in(code_valid_in),
    .in_ready_out(code_ready_out),
    .in_data_in(code_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(r.st != video_recon_pkg::ST_HALT),
    .out_data_out(sym)
  );

  assign pop = fifo_valid && (r.st != video_recon_pkg::ST_HALT);
  assign advance = pop && (((r.st == video_recon_pkg::ST_RUN)
                   && (sym.kind != video_recon_pkg::KIND_HSYNC)
                   && (sym.kind != video_recon_pkg::KIND_VSYNC))
                   || (r.st == video_recon_pkg::ST_PRIME));

  assign sum = r.delta_neg ? ({1'b0, r.video} - {1'b0, r.delta_mag})
                           : ({1'b0, r.video} + {1'b0, r.delta_mag});
  assign out_of_range = sum[6];

  assign dac_sample_out = r.dac;
  assign halted_out = (r.st == video_recon_pkg::ST_HALT);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    // Panel switch is asynchronous, acted on once two late stages agree
    next_r.sel_sync = {r.sel_sync[1:0], source_select_switch_in};
    if (r.sel_sync[2] == r.sel_sync[1]) begin
      next_r.sel = r.sel_sync[2];
    end
    if (advance) begin
      next_r.justified = lsb_just(sym.word, r.quant_level);
      next_r.held = r.justified;
      next_r.code_stage = sym;
      next_r.code_hold = r.code_stage;
      // delta built as the code enters the hold stage
      next_r.delta_neg = r.code_stage.word[video_recon_pkg::DELTA_SIGN_BIT];
      next_r.delta_mag =
        video_recon_pkg::DELTA_MAG[r.code_stage.word[video_recon_pkg::DELTA_IDX_W-1:0]];
    end
    unique case (r.st)
      video_recon_pkg::ST_RUN: begin
        if (pop) begin
          if ((sym.kind == video_recon_pkg::KIND_HSYNC)
              || (sym.kind == video_recon_pkg::KIND_VSYNC)) begin
            next_r.st = video_recon_pkg::ST_DISCARD;
          end else if (r.code_hold.kind == video_recon_pkg::KIND_ABS) begin
            next_r.video = r.held;
          end else if (r.code_hold.kind == video_recon_pkg::KIND_DELTA) begin
            if (!out_of_range) begin
              next_r.video = sum[5:0];
            end
          end
        end
      end
      video_recon_pkg::ST_DISCARD: begin
        if (pop) begin
          next_r.st = video_recon_pkg::ST_LOAD_ABS;
        end
      end
      video_recon_pkg::ST_LOAD_ABS: begin
        if (pop) begin
          next_r.video = sym.word;
          next_r.st = video_recon_pkg::ST_LOAD_QL;
        end
      end
      video_recon_pkg::ST_LOAD_QL: begin
        // level waits for the next line
        if (pop) begin
          next_r.quant_pending = sym.word[video_recon_pkg::QL_W-1:0];
          next_r.prime_cnt = '0;
          next_r.st = video_recon_pkg::ST_PRIME;
        end
      end
      video_recon_pkg::ST_PRIME: begin
        // fill pipeline without touching video value
        if (pop) begin
          next_r.prime_cnt = r.prime_cnt + 2'h1;
          if (r.prime_cnt == video_recon_pkg::PRIME_WORDS - 2'h1) begin
            next_r.st = video_recon_pkg::ST_HALT;
          end
        end
      end
      video_recon_pkg::ST_HALT: begin
        // wait for restart; new precision applies here
        if (restart_in) begin
          next_r.quant_level = r.quant_pending;
          next_r.st = video_recon_pkg::ST_RUN;
        end
      end
      default: next_r.st = video_recon_pkg::ST_RUN;
    endcase
    next_r.dac = r.sel ? msb_just(r.video, r.quant_level) : recon_sample_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      r <= '0;
      r.st <= video_recon_pkg::ST_RUN;
      r.quant_level <= video_recon_pkg::QL_RESET;
      r.quant_pending <= video_recon_pkg::QL_RESET;
      r.code_stage.kind <= video_recon_pkg::KIND_RAW;
      r.code_hold.kind <= video_recon_pkg::KIND_RAW;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  logic run_pop;
  assign run_pop = pop && (r.st == video_recon_pkg::ST_RUN)
                   && (sym.kind != video_recon_pkg::KIND_HSYNC)
                   && (sym.kind != video_recon_pkg::KIND_VSYNC);

  a_stage_move: assert property (advance |=> (r.held == $past(r.justified))
    && (r.code_hold == $past(r.code_stage)))
    else $error("pipeline stages did not move");
  a_abs_select: assert property (
    run_pop && (r.code_hold.kind == video_recon_pkg::KIND_ABS)
    |=> r.video == $past(r.held))
    else $error("absolute code did not load held sample");
  a_delta_sum: assert property (
    run_pop && (r.code_hold.kind == video_recon_pkg::KIND_DELTA) && !out_of_range
    |=> r.video == $past(sum[5:0]))
    else $error("delta sum not written");
  a_overflow_hold: assert property (
    run_pop && (r.code_hold.kind == video_recon_pkg::KIND_DELTA) && out_of_range
    |=> $stable(r.video))
    else $error("wrapped delta updated video value");
  a_sync_sequence: assert property (
    pop && (r.st == video_recon_pkg::ST_RUN) && (sym.kind == video_recon_pkg::KIND_VSYNC)
    |=> r.st == video_recon_pkg::ST_DISCARD)
    else $error("sync did not start end-of-line sequence");
  a_eol_abs: assert property (
    pop && (r.st == video_recon_pkg::ST_LOAD_ABS)
    |=> (r.video == $past(sym.word)) && (r.st == video_recon_pkg::ST_LOAD_QL))
    else $error("absolute value not loaded after discard");
  a_prime_halt: assert property (
    pop && (r.st == video_recon_pkg::ST_PRIME) && (r.prime_cnt == 2'h2)
    |=> r.st == video_recon_pkg::ST_HALT)
    else $error("halt not reached after three words");
  a_halt_wait: assert property (
    halted_out && !restart_in |=> halted_out && !$changed(r.video))
    else $error("left halt without restart");
  a_dac_msb: assert property (
    r.sel |=> dac_sample_out == msb_just($past(r.video), $past(r.quant_level)))
    else $error("decoder sample not MSB aligned");
  a_dac_recon: assert property (
    !r.sel |=> dac_sample_out == $past(recon_sample_in))
    else $error("reconstructor sample not routed");

  c_delta_update: cover property (run_pop && (r.code_hold.kind == video_recon_pkg::KIND_DELTA)
    && !out_of_range);
  c_overflow: cover property (run_pop && (r.code_hold.kind == video_recon_pkg::KIND_DELTA)
    && out_of_range);
  c_restart: cover property (halted_out && restart_in);
endmodule

// >>> video_delta_value_reconstructor_test.sv
module video_delta_value_reconstructor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic code_valid_in;
  logic code_ready_out;
  video_recon_pkg::sym_code_t code_in;
  logic restart_in = 1'b0;
  logic [5:0] recon_sample_in = 6'h15;
  logic source_select_switch_in = 1'b1;
  logic [5:0] dac_sample_out;
  logic halted_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  code_source src (
    .sys_clk_in(sys_clk_in),
    .code_ready_in(code_ready_out),
    .code_valid_out(code_valid_in),
    .code_out(code_in)
  );
  video_delta_value_reconstructor dut (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .code_valid_in(code_valid_in),
    .code_ready_out(code_ready_out),
    .code_in(code_in),
    .restart_in(restart_in),
    .recon_sample_in(recon_sample_in),
    .source_select_switch_in(source_select_switch_in),
    .dac_sample_out(dac_sample_out),
    .halted_out(halted_out)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic drain();
    int guard;
    guard = 0;
    while (src.pending() > 0 && guard < 200) begin
      tick(1);
      guard++;
    end
    // Words still in the buffer drain one per cycle, so wait out a full buffer
    tick(video_recon_pkg::FIFO_DEPTH + 8);
  endtask
  task automatic abs_word(input logic [5:0] w);
    src.send(video_recon_pkg::KIND_ABS, w);
  endtask
  task automatic raw(input int n, input logic [5:0] w);
    repeat (n) src.send(video_recon_pkg::KIND_RAW, w);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_abs();
    abs_word(6'h20);
    raw(3, 6'h00);
    drain();
    chk(dac_sample_out, 6'h20);
  endtask
  task automatic t_delta();
    int acc;
    acc = 0;
    abs_word(6'h00);
    for (int i = 0; i < 8; i++) begin
      src.send(video_recon_pkg::KIND_DELTA, {3'h0, i[2:0]});
      if (acc + video_recon_pkg::DELTA_MAG[i] <= 63) acc += video_recon_pkg::DELTA_MAG[i];
    end
    raw(3, 6'h00);
    drain();
    chk(dac_sample_out, acc[5:0]);
    acc = acc - 27;
    src.send(video_recon_pkg::KIND_DELTA, 6'h0f);
    src.send(video_recon_pkg::KIND_DELTA, 6'h0f);
    raw(3, 6'h00);
    drain();
    chk(dac_sample_out, acc[5:0]);
  endtask
  task automatic t_sync(input video_recon_pkg::code_kind_t kind, input logic [1:0] ql,
                        input logic [5:0] v, input int old_sh, input int new_sh);
    src.send(kind, 6'h00);
    abs_word(6'h3f);
    abs_word(v);
    raw(1, {4'h0, ql});
    raw(3, 6'h00);
    drain();
    chk({5'h0, halted_out}, 6'h01);
    chk(dac_sample_out, v << old_sh);
    raw(34, 6'h00);
    tick(40);
    chk({5'h0, code_ready_out}, 6'h00);
    chk({5'h0, halted_out}, 6'h01);
    restart_in = 1'b1;
    tick(1);
    restart_in = 1'b0;
    drain();
    chk({5'h0, halted_out}, 6'h00);
    chk(dac_sample_out, v << new_sh);
  endtask
  task automatic t_quant();
    abs_word(6'h30);
    raw(3, 6'h00);
    drain();
    chk(dac_sample_out, 6'h30);
    src.send(video_recon_pkg::KIND_DELTA, 6'h00);
    raw(3, 6'h00);
    drain();
    chk(dac_sample_out, 6'h34);
  endtask
  task automatic t_source();
    source_select_switch_in = 1'b0;
    tick(6);
    chk(dac_sample_out, 6'h15);
    recon_sample_in = 6'h2a;
    tick(2);
    chk(dac_sample_out, 6'h2a);
    source_select_switch_in = 1'b1;
    tick(6);
    chk(dac_sample_out, 6'h34);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    srst_in = 1'b0;
    chk(dac_sample_out, 6'h00);
    chk({5'h0, code_ready_out}, 6'h01);
    t_abs();
    t_delta();
    t_sync(video_recon_pkg::KIND_HSYNC, video_recon_pkg::QL_FIVE, 6'h11, 0, 1);
    t_sync(video_recon_pkg::KIND_VSYNC, video_recon_pkg::QL_FOUR, 6'h0a, 1, 2);
    t_quant();
    t_source();
    tally_and_finish();
  end
endmodule

// >>> video_recon_pkg.sv
package video_recon_pkg;

  // Sample word and quantization
  localparam int SAMPLE_W = 6;
  localparam int QL_W = 2;
  localparam logic [1:0] QL_SIX = 2'h0;
  localparam logic [1:0] QL_FIVE = 2'h1;
  localparam logic [1:0] QL_FOUR = 2'h2;
  localparam logic [1:0] QL_RESET = QL_SIX;

  // Delta code layout inside the word field
  localparam int DELTA_SIGN_BIT = 3;
  localparam int DELTA_IDX_W = 3;

  // Magnitude per delta index, LSB-justified units
  localparam logic [5:0] DELTA_MAG [8] = '{6'h01, 6'h02, 6'h03, 6'h05,
                                           6'h08, 6'h0c, 6'h12, 6'h1b};

  // End-of-line priming words
  localparam logic [1:0] PRIME_WORDS = 2'h3;

  // Input buffer shape
  localparam int FIFO_DEPTH = 32;

  // Kind of each detected code word
  typedef enum logic [2:0] {
    KIND_ABS,
    KIND_DELTA,
    KIND_HSYNC,
    KIND_VSYNC,
    KIND_RAW
  } code_kind_t;

  typedef struct packed {
    code_kind_t kind;
    logic [SAMPLE_W-1:0] word;
  } sym_code_t;

  localparam int SYM_W = $bits(sym_code_t);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DISCARD,
    ST_LOAD_ABS,
    ST_LOAD_QL,
    ST_PRIME,
    ST_HALT
  } dec_state_t;

endpackage
